// File: acr_readout.sv
// Conversion timing and serial master readout for the sampling converter.
`timescale 1ns/10ps
`default_nettype none
module acr_readout
(
    // Clock and synchronous reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Pins from the host, asynchronous to ref_clk.
    input wire logic convert_start_n,
    input wire logic csN,
    input wire logic serialMaster,
    input wire logic readDuring,
    input wire logic [1:0] serial_clock_divider,
    // Sample word from the converter core, on ref_clk.
    input wire logic [17:0] sampleIn,
    // Conversion status and parallel result.
    output logic busy,
    output logic dataValid,
    output logic [17:0] resultData,
    // Serial pins: levels and output enables.
    output acr_pkg::acr_serial_type serOut,
    output acr_pkg::acr_serial_type serOe
);

    // Raw pins gathered into one word.
    acr_pkg::acr_pins_type pinsRaw;
    // First synchroniser stage, read only by the second.
    acr_pkg::acr_pins_type pinsMeta_r;
    // Second synchroniser stage, used by all logic.
    acr_pkg::acr_pins_type pins_r;
    // Start level one cycle older, for edge detection.
    logic startDly_r;
    // Falling edge of the start strobe.
    logic startFall;
    // Conversion in progress and its countdown.
    logic converting_r;
    logic [acr_pkg::CNT_W-1:0] convCnt_r;
    // One-cycle end of conversion event.
    logic eoc_r;
    // Busy flag and the parallel result.
    logic busy_r;
    logic dataValid_r;
    logic [17:0] result_r;
    // Mode held for the whole conversion.
    logic modeMaster_r;
    logic modeDuring_r;
    logic [1:0] modeDiv_r;
    // Cycles since the start, saturating.
    logic [acr_pkg::CNT_W-1:0] since_r;
    // Serial transfer state.
    acr_pkg::acr_ser_state_type serState_r;
    logic [acr_pkg::CNT_W-1:0] serCnt_r;
    logic [4:0] bitCnt_r;
    logic [17:0] shift_r;
    logic sclk_r;
    logic frame_r;
    // Serial transfer has ended, one-cycle pulse.
    logic serDone_r;
    // Frame start requests from the two read modes.
    logic kickAfter;
    logic kickDuring;
    // Timing figures for the active transfer: clock high, clock low, lead and tail.
    logic [acr_pkg::CNT_W-1:0] highCyc;
    logic [acr_pkg::CNT_W-1:0] lowCyc;
    logic [acr_pkg::CNT_W-1:0] leadCyc;
    logic [acr_pkg::CNT_W-1:0] tailCyc;
    // Output enable shared by the three serial pins.
    logic oe_r;

    // Gather the asynchronous pins for the synchroniser.
    assign pinsRaw.convStartN = convert_start_n;
    assign pinsRaw.csN = csN;
    assign pinsRaw.serialMaster = serialMaster;
    assign pinsRaw.readDuring = readDuring;
    assign pinsRaw.divider = serial_clock_divider;

    // Two flip-flops on every pin before any logic reads it.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            pinsMeta_r <= '{convStartN: 1'b1, csN: 1'b1, default: '0};
            pins_r <= '{convStartN: 1'b1, csN: 1'b1, default: '0};
        end
        else
        begin
            pinsMeta_r <= pinsRaw;
            pins_r <= pinsMeta_r;
        end
    end

    // Remember the previous start level; idle level is high.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            startDly_r <= 1'b1;
        end
        else
        begin
            startDly_r <= pins_r.convStartN;
        end
    end

    // A start only counts while the converter is free.
    assign startFall = startDly_r & ~pins_r.convStartN & ~busy_r;

    // Conversion countdown; the end event fires once per start.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            converting_r <= 1'b0;
            convCnt_r <= '0;
            eoc_r <= 1'b0;
        end
        else if (startFall)
        begin
            converting_r <= 1'b1;
            convCnt_r <= acr_pkg::CNT_W'(acr_pkg::CONV_CYC - 1);
            eoc_r <= 1'b0;
        end
        else if (converting_r && convCnt_r == '0)
        begin
            // The conversion time fits the start-to-data bound.
            converting_r <= 1'b0;
            eoc_r <= 1'b1;
        end
        else
        begin
            convCnt_r <= converting_r ? convCnt_r - 1'b1 : convCnt_r;
            eoc_r <= 1'b0;
        end
    end

    // Latch the mode pins at each start so a change cannot tear a read.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            modeMaster_r <= 1'b0;
            modeDuring_r <= 1'b0;
            modeDiv_r <= 2'h0;
        end
        else if (startFall)
        begin
            modeMaster_r <= pins_r.serialMaster;
            modeDuring_r <= pins_r.readDuring;
            modeDiv_r <= pins_r.divider;
        end
    end

    // Capture the result at the end of conversion, no pipeline.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            result_r <= '0;
            dataValid_r <= 1'b0;
        end
        else if (startFall)
        begin
            dataValid_r <= 1'b0;
        end
        else if (converting_r && convCnt_r == '0)
        begin
            result_r <= sampleIn;
            dataValid_r <= 1'b1;
        end
    end

    // Busy rises at the start and, outside read-after, falls one cycle after the result
    // is valid, so data leads busy by a full period.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            busy_r <= 1'b0;
        end
        else if (startFall)
        begin
            busy_r <= 1'b1;
        end
        else if (eoc_r && !(modeMaster_r && !modeDuring_r))
        begin
            // Busy ends well inside 1.5 us of the start.
            busy_r <= 1'b0;
        end
        else if (serDone_r && modeMaster_r && !modeDuring_r)
        begin
            // Busy follows the frame drop by one cycle.
            busy_r <= 1'b0;
        end
    end

    // Count cycles since the start, for the read-during frame.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            since_r <= '1;
        end
        else if (startFall)
        begin
            since_r <= '0;
        end
        else if (since_r != '1)
        begin
            since_r <= since_r + 1'b1;
        end
    end

    // Read-after starts its frame at the end of conversion.
    assign kickAfter = eoc_r & modeMaster_r & ~modeDuring_r;
    // Read-during starts its frame 525 ns after the start.
    assign kickDuring = modeMaster_r & modeDuring_r &
        (since_r == acr_pkg::CNT_W'(acr_pkg::DUR_SYNC_CYC - 2));

    // Clock timing from the divider, fastest in read-during.
    always_comb
    begin
        highCyc = acr_pkg::CNT_W'(acr_pkg::HIGH0_CYC);
        lowCyc = acr_pkg::CNT_W'(acr_pkg::LOW0_CYC);
        leadCyc = acr_pkg::CNT_W'(acr_pkg::LEAD_FAST_CYC);
        tailCyc = acr_pkg::CNT_W'(acr_pkg::TAIL0_CYC);
        if (!modeDuring_r)
        begin
            // Uneven high and low keep the slow periods inside their range.
            unique case (modeDiv_r)
                2'h0:
                begin
                    highCyc = acr_pkg::CNT_W'(acr_pkg::HIGH0_CYC);
                    lowCyc = acr_pkg::CNT_W'(acr_pkg::LOW0_CYC);
                end
                2'h1:
                begin
                    highCyc = acr_pkg::CNT_W'(acr_pkg::HIGH1_CYC);
                    lowCyc = acr_pkg::CNT_W'(acr_pkg::LOW1_CYC);
                    leadCyc = acr_pkg::CNT_W'(acr_pkg::LEAD_SLOW_CYC);
                    tailCyc = acr_pkg::CNT_W'(acr_pkg::TAIL1_CYC);
                end
                2'h2:
                begin
                    highCyc = acr_pkg::CNT_W'(acr_pkg::HIGH2_CYC);
                    lowCyc = acr_pkg::CNT_W'(acr_pkg::LOW2_CYC);
                    leadCyc = acr_pkg::CNT_W'(acr_pkg::LEAD_SLOW_CYC);
                    tailCyc = acr_pkg::CNT_W'(acr_pkg::TAIL2_CYC);
                end
                2'h3:
                begin
                    highCyc = acr_pkg::CNT_W'(acr_pkg::HIGH3_CYC);
                    lowCyc = acr_pkg::CNT_W'(acr_pkg::LOW3_CYC);
                    leadCyc = acr_pkg::CNT_W'(acr_pkg::LEAD_SLOW_CYC);
                    tailCyc = acr_pkg::CNT_W'(acr_pkg::TAIL3_CYC);
                end
            endcase
        end
    end

    // Serial master: frame, lead, 18 clocks MSB first, tail.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            serState_r <= acr_pkg::SER_IDLE;
            serCnt_r <= '0;
            bitCnt_r <= 5'h00;
            shift_r <= '0;
            sclk_r <= 1'b0;
            frame_r <= 1'b0;
            serDone_r <= 1'b0;
        end
        else
        begin
            serDone_r <= 1'b0;
            unique case (serState_r)
                acr_pkg::SER_IDLE:
                begin
                    // Read-after sends the word just captured, read-during
                    // the previous one; both sit in the result register.
                    if (kickAfter || kickDuring)
                    begin
                        shift_r <= result_r;
                        frame_r <= 1'b1;
                        serCnt_r <= leadCyc - 1'b1;
                        serState_r <= acr_pkg::SER_LEAD;
                    end
                end
                acr_pkg::SER_LEAD:
                begin
                    // Hold off the first edge after the frame.
                    if (serCnt_r == '0)
                    begin
                        serCnt_r <= lowCyc - 1'b1;
                        bitCnt_r <= 5'(acr_pkg::RES_W);
                        serState_r <= acr_pkg::SER_SHIFT;
                    end
                    else
                    begin
                        serCnt_r <= serCnt_r - 1'b1;
                    end
                end
                acr_pkg::SER_SHIFT:
                begin
                    if (serCnt_r != '0)
                    begin
                        serCnt_r <= serCnt_r - 1'b1;
                    end
                    else if (!sclk_r)
                    begin
                        // Rising edge: host samples the present bit.
                        sclk_r <= 1'b1;
                        serCnt_r <= highCyc - 1'b1;
                    end
                    else
                    begin
                        // Falling edge: move to the next bit.
                        sclk_r <= 1'b0;
                        shift_r <= {shift_r[16:0], 1'b0};
                        bitCnt_r <= bitCnt_r - 1'b1;
                        serCnt_r <= lowCyc - 1'b1;
                        if (bitCnt_r == 5'h01)
                        begin
                            serCnt_r <= tailCyc - 1'b1;
                            serState_r <= acr_pkg::SER_TAIL;
                        end
                    end
                end
                acr_pkg::SER_TAIL:
                begin
                    // Keep the frame after the last edge.
                    if (serCnt_r == '0)
                    begin
                        frame_r <= 1'b0;
                        serDone_r <= 1'b1;
                        serState_r <= acr_pkg::SER_IDLE;
                    end
                    else
                    begin
                        serCnt_r <= serCnt_r - 1'b1;
                    end
                end
                default:
                begin
                    serState_r <= acr_pkg::SER_IDLE;
                end
            endcase
        end
    end

    // Pins drive only in serial master mode with chip select low.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            oe_r <= 1'b0;
        end
        else
        begin
            // Low select drives only with serialMaster high, high select floats.
            oe_r <= ~pins_r.csN & pins_r.serialMaster;
        end
    end

    // Outputs.
    assign busy = busy_r;
    assign dataValid = dataValid_r;
    assign resultData = result_r;
    assign serOut.frameSync = frame_r;
    assign serOut.sclk = sclk_r;
    assign serOut.sdo = shift_r[17];
    assign serOe = {3{oe_r}};

endmodule
`default_nettype wire

// File: acr_pkg.sv
// Package of constants and carrier types for the conversion readout timer.
// Function
// - Busy ends within 1.5 us, except read-after.
// - Result valid 20 ns before busy falls.
// - Result valid within 1.5 us of start.
// - Busy falls 10 ns after conversion end.
// - Read-after frame starts after conversion completes.
// - Read-after busy falls 25 ns after frame.
// - Read-during frame starts 525 ns after start.
// - Divider setting selects serial clock period.
// - Read-after busy bounded per divider setting.
// - Frame-to-first-clock lead of 3 or 17 ns.
// - Last clock to frame change, 3-300 ns.
// - Read-during always uses the fastest clock.
// - Chip select low enables serial outputs; here only with serialMaster high.
// - Chip select high floats serial outputs.
// - Each result available at once, no pipeline.
package acr_pkg;

    // Clock period in nanoseconds.
    localparam int CLK_NS = 50;
    // Result width in bits.
    localparam int RES_W = 18;
    // Conversion time in nanoseconds, inside the 1.5 us bound.
    localparam int CONV_NS = 1050;
    localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
    // Start to frame delay in read-during mode, in nanoseconds.
    localparam int DUR_SYNC_NS = 525;
    localparam int DUR_SYNC_CYC = (DUR_SYNC_NS + CLK_NS - 1) / CLK_NS;
    // Least lead from frame to first clock edge, fast and slow.
    localparam int LEAD_FAST_NS = 3;
    localparam int LEAD_SLOW_NS = 17;
    localparam int LEAD_FAST_CYC = (LEAD_FAST_NS + CLK_NS - 1) / CLK_NS;
    localparam int LEAD_SLOW_CYC = (LEAD_SLOW_NS + CLK_NS - 1) / CLK_NS;
    // Least time from last clock edge to frame change, per setting.
    localparam int TAIL0_NS = 3;
    localparam int TAIL1_NS = 60;
    localparam int TAIL2_NS = 140;
    localparam int TAIL3_NS = 300;
    localparam int TAIL0_CYC = (TAIL0_NS + CLK_NS - 1) / CLK_NS;
    localparam int TAIL1_CYC = (TAIL1_NS + CLK_NS - 1) / CLK_NS;
    localparam int TAIL2_CYC = (TAIL2_NS + CLK_NS - 1) / CLK_NS;
    localparam int TAIL3_CYC = (TAIL3_NS + CLK_NS - 1) / CLK_NS;
    // Least serial clock period per setting, rounded up to whole cycles.
    // Two cycles is the floor, so settings 00 and 01 run slower.
    localparam int PER1_NS = 60;
    localparam int PER2_NS = 120;
    localparam int PER3_NS = 240;
    localparam int PER0_CYC = 2;
    localparam int PER1_CYC = (PER1_NS + CLK_NS - 1) / CLK_NS;
    localparam int PER2_CYC = (PER2_NS + CLK_NS - 1) / CLK_NS;
    localparam int PER3_CYC = (PER3_NS + CLK_NS - 1) / CLK_NS;
    // Clock high takes the larger part of an odd period, low the rest.
    localparam int HIGH0_CYC = (PER0_CYC + 1) / 2;
    localparam int HIGH1_CYC = (PER1_CYC + 1) / 2;
    localparam int HIGH2_CYC = (PER2_CYC + 1) / 2;
    localparam int HIGH3_CYC = (PER3_CYC + 1) / 2;
    localparam int LOW0_CYC = PER0_CYC - HIGH0_CYC;
    localparam int LOW1_CYC = PER1_CYC - HIGH1_CYC;
    localparam int LOW2_CYC = PER2_CYC - HIGH2_CYC;
    localparam int LOW3_CYC = PER3_CYC - HIGH3_CYC;
    // Width of the small timing counters.
    localparam int CNT_W = 6;

    // Pin inputs that pass the two-stage synchroniser together.
    typedef struct packed {
        logic convStartN;
        logic csN;
        logic serialMaster;
        logic readDuring;
        logic [1:0] divider;
    } acr_pins_type;

    // Serial output levels or enables, one bit per pin.
    typedef struct packed {
        logic frameSync;
        logic sclk;
        logic sdo;
    } acr_serial_type;

    // States of the serial master transfer.
    typedef enum logic [2:0] {
        SER_IDLE,
        SER_LEAD,
        SER_SHIFT,
        SER_TAIL
    } acr_ser_state_type;

endpackage

// File: acr_readout_note_end.sv
// Holds no logic; the whole readout block lives in acr_readout.sv.

// File: acr_readout_monitor.sv
// Checker of conversion and serial readout timing at the block's ports.
`timescale 1ns/10ps
`default_nettype none
module acr_readout_monitor
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Host pins and converter word.
    input wire logic convert_start_n,
    input wire logic csN,
    input wire logic serialMaster,
    input wire logic readDuring,
    input wire logic [1:0] serial_clock_divider,
    input wire logic [17:0] sampleIn,
    // Block outputs.
    input wire logic busy,
    input wire logic dataValid,
    input wire logic [17:0] resultData,
    input wire acr_pkg::acr_serial_type serOut,
    input wire acr_pkg::acr_serial_type serOe
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    // Cycles since the last serial clock rise; zero before a frame's first.
    logic [3:0] perCnt;
    // Serial clock period that the current mode calls for, in cycles.
    logic [3:0] perExp;
    // Read-during always runs at the fastest period.
    assign perExp = (readDuring || serial_clock_divider == 2'h0) ?
        4'(acr_pkg::PER0_CYC) : (serial_clock_divider == 2'h1) ?
        4'(acr_pkg::PER1_CYC) : (serial_clock_divider == 2'h2) ?
        4'(acr_pkg::PER2_CYC) : 4'(acr_pkg::PER3_CYC);
    // Measures the spacing of serial clock rises within one frame.
    always_ff @(posedge ref_clk)
    begin
        if (srst || $rose(serOut.frameSync))
            perCnt <= 4'h0;
        else if ($rose(serOut.sclk))
            perCnt <= 4'h1;
        else if (perCnt != 4'h0 && perCnt != 4'hF)
            perCnt <= perCnt + 4'h1;
    end
    a_busy_width: assert property (
        $rose(busy) && !(serialMaster && !readDuring) |-> ##22 $fell(busy))
        else $error("busy width wrong");
    a_valid_before_fall: assert property (
        $fell(busy) |-> $past(dataValid))
        else $error("result not valid before busy fell");
    a_valid_delay: assert property (
        $rose(busy) |-> ##21 $rose(dataValid))
        else $error("result late or early");
    a_end_gap: assert property (
        $rose(dataValid) |-> busy)
        else $error("busy fell with conversion end");
    a_after_frame: assert property (
        $rose(dataValid) && serialMaster && !readDuring
        |-> ##1 $rose(serOut.frameSync))
        else $error("read-after frame wrong");
    a_frame_busy: assert property (
        $fell(serOut.frameSync) && serialMaster && !readDuring
        |-> ##1 $fell(busy))
        else $error("busy not after frame");
    a_during_frame: assert property (
        $rose(busy) && serialMaster && readDuring
        |-> ##10 $rose(serOut.frameSync))
        else $error("read-during frame wrong");
    a_clock_period: assert property (
        $rose(serOut.sclk) && perCnt != 4'h0 |-> perCnt == perExp)
        else $error("serial clock period wrong");
    a_frame_lead: assert property (
        $rose(serOut.frameSync) |-> !serOut.sclk ##1 !serOut.sclk)
        else $error("no lead before first clock");
    a_frame_tail: assert property (
        $fell(serOut.frameSync) |-> !serOut.sclk && !$past(serOut.sclk))
        else $error("no tail");
    a_cs_drive: assert property (
        $fell(csN) && serialMaster |-> ##[1:4] serOe == 3'h7)
        else $error("outputs not driven");
    a_cs_float: assert property (
        $rose(csN) |-> ##[1:4] serOe == 3'h0)
        else $error("outputs not released");
endmodule
bind acr_readout acr_readout_monitor u_mon (.ref_clk(ref_clk), .srst(srst),
    .convert_start_n(convert_start_n), .csN(csN),
    .serialMaster(serialMaster), .readDuring(readDuring),
    .serial_clock_divider(serial_clock_divider), .sampleIn(sampleIn),
    .busy(busy), .dataValid(dataValid), .resultData(resultData),
    .serOut(serOut), .serOe(serOe));
`default_nettype wire

// File: acr_host_rx.sv
// Host-side serial receiver that collects each framed result word.
`timescale 1ns/10ps
`default_nettype none
module acr_host_rx
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Serial line levels as the host sees them.
    input wire acr_pkg::acr_serial_type line,
    // Collected word, its bit count and a frame-finished flag.
    output logic [17:0] rxWord,
    output logic [5:0] rxBits,
    output logic rxDone
);
    // Previous line levels, for edge detection.
    acr_pkg::acr_serial_type lineOld;
    // Takes the data bit at each clock rise inside a frame, MSB first.
    always @(posedge ref_clk)
    begin
        lineOld <= line;
        if (srst || (line.frameSync && !lineOld.frameSync))
        begin
            rxBits <= 6'h0;
            rxDone <= 1'b0;
        end
        else if (lineOld.frameSync && !line.frameSync)
            rxDone <= 1'b1;
        if (line.frameSync && line.sclk && !lineOld.sclk)
        begin
            rxWord <= {rxWord[16:0], line.sdo};
            rxBits <= rxBits + 6'h1;
        end
    end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench for the conversion readout timer.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // Design pins.
    logic ref_clk, srst, convert_start_n, csN, serialMaster, readDuring;
    logic [1:0] serial_clock_divider;
    logic [17:0] sampleIn, resultData, rxWord, lastRes;
    logic busy, dataValid, rxDone;
    logic [5:0] rxBits;
    acr_pkg::acr_serial_type serOut, serOe, serLine;
    // Last driven level of each line; a floating line shows its inverse.
    acr_pkg::acr_serial_type serLast = '0;
    int seed, err_total, n_checks;
    acr_readout u_dut (.ref_clk(ref_clk), .srst(srst),
        .convert_start_n(convert_start_n), .csN(csN),
        .serialMaster(serialMaster), .readDuring(readDuring),
        .serial_clock_divider(serial_clock_divider), .sampleIn(sampleIn),
        .busy(busy), .dataValid(dataValid), .resultData(resultData),
        .serOut(serOut), .serOe(serOe));
    acr_host_rx u_host (.ref_clk(ref_clk), .srst(srst), .line(serLine),
        .rxWord(rxWord), .rxBits(rxBits), .rxDone(rxDone));
    // Resolves each serial wire from level and enable.
    always @(posedge ref_clk)
        serLast <= (serOe & serOut) | (~serOe & serLast);
    assign serLine = (serOe & serOut) | (~serOe & ~serLast);
    // Clock of 50 ns period.
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        begin
            $display("checks %0d mismatches %0d", n_checks, err_total);
            if (err_total == 0 && n_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // Compares one seen value with its expectation.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            n_checks++;
            if (seen !== exp)
            begin
                err_total++;
                $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
            end
        end
    endtask
    // Waits, bounded, for busy, dataValid or rxDone to reach a level.
    task automatic waitFor(input int sel, input logic lvl, output int n);
        logic s;
        begin
            n = 0;
            do
            begin
                @(posedge ref_clk);
                #1;
                s = (sel == 0) ? busy : (sel == 1) ? dataValid : rxDone;
                n++;
            end while (s !== lvl && n < 400);
            if (s !== lvl)
            begin
                err_total++;
                $display("[FAIL] %0t wait ran out", $time);
                conclude();
            end
        end
    endtask
    // Busy width in cycles that the rules and timing constants give.
    function automatic int expBusy(input logic sm, input logic rd,
        input logic [1:0] div);
        int per, tail, lead;
        begin
            per = (div == 2'h0) ? acr_pkg::PER0_CYC : (div == 2'h1) ?
                acr_pkg::PER1_CYC : (div == 2'h2) ? acr_pkg::PER2_CYC :
                acr_pkg::PER3_CYC;
            tail = (div == 2'h0) ? acr_pkg::TAIL0_CYC : (div == 2'h1) ?
                acr_pkg::TAIL1_CYC : (div == 2'h2) ? acr_pkg::TAIL2_CYC :
                acr_pkg::TAIL3_CYC;
            lead = (div == 2'h0) ? acr_pkg::LEAD_FAST_CYC :
                acr_pkg::LEAD_SLOW_CYC;
            // Without a read-after transfer, busy ends after the result.
            if (!sm || rd)
                return acr_pkg::CONV_CYC + 1;
            // Otherwise it covers frame, lead, 18 periods and the tail.
            return acr_pkg::CONV_CYC + 2 + lead + acr_pkg::RES_W * per +
                tail;
        end
    endfunction
    // Pulses the start pin low for two cycles.
    task automatic pulseStart();
        begin
            @(posedge ref_clk);
            convert_start_n <= 1'b0;
            repeat (2) @(posedge ref_clk);
            convert_start_n <= 1'b1;
        end
    endtask
    // One conversion with optional refused start and chip-select drop.
    task automatic convert(input logic sm, input logic rd,
        input logic [1:0] div, input logic refuse, input logic dropCs);
        int n1, n2, n3, t0;
        logic [17:0] smp;
        begin
            t0 = 0;
            smp = 18'($random(seed));
            @(posedge ref_clk);
            sampleIn <= smp;
            serialMaster <= sm;
            readDuring <= rd;
            serial_clock_divider <= div;
            csN <= !sm;
            repeat (6) @(posedge ref_clk);
            pulseStart();
            waitFor(0, 1'b1, n1);
            if (refuse)
            begin
                pulseStart();
                t0 = 3;
            end
            waitFor(1, 1'b1, n2);
            check(n2 + t0, acr_pkg::CONV_CYC);
            check(resultData, smp);
            if (dropCs)
            begin
                @(posedge ref_clk);
                csN <= 1'b1;
                repeat (5) @(posedge ref_clk);
                #1;
                check(serOe, 3'h0);
                @(posedge ref_clk);
                csN <= 1'b0;
                repeat (5) @(posedge ref_clk);
                #1;
                check(serOe, 3'h7);
                // Twelve edges passed here outside the busy count.
                t0 = t0 + 12;
            end
            waitFor(0, 1'b0, n3);
            check(dataValid, 1'b1);
            if (!(sm && !rd))
                check(n2 + n3 + t0, expBusy(sm, rd, div));
            else
                check(n2 + n3 + t0, expBusy(sm, rd, div));
            if (sm && !dropCs)
            begin
                waitFor(2, 1'b1, n1);
                check(rxBits, 18);
                check(rxWord, rd ? lastRes : smp);
            end
            lastRes = smp;
            repeat (200) @(posedge ref_clk);
            $display("test sm=%0d rd=%0d div=%0d done", sm, rd, div);
        end
    endtask
    // Main sequence: reset, corner cases, random conversions, mid-run reset.
    initial
    begin
        seed = 44580;
        err_total = 0;
        n_checks = 0;
        lastRes = 18'h0;
        srst = 1'b1;
        convert_start_n = 1'b1;
        csN = 1'b1;
        serialMaster = 1'b0;
        readDuring = 1'b0;
        serial_clock_divider = 2'h0;
        sampleIn = 18'h0;
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        for (int d = 0; d < 4; d++)
            convert(1'b1, 1'b0, d[1:0], 1'b0, 1'b0);
        convert(1'b1, 1'b1, 2'h3, 1'b0, 1'b0);
        convert(1'b0, 1'b0, 2'h0, 1'b1, 1'b0);
        convert(1'b1, 1'b0, 2'h1, 1'b0, 1'b1);
        for (int k = 0; k < 4; k++)
            convert(1'($random(seed)), 1'($random(seed)), 2'($random(seed)),
                1'b0, 1'b0);
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        // Reset clears the held result, so read-during next sends zeros.
        lastRes = 18'h0;
        #1;
        check(busy, 1'b0);
        check(dataValid, 1'b0);
        convert(1'b1, 1'b1, 2'h2, 1'b0, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
